// >>> core/mic_params.svh
`ifndef MIC_PARAMS_SVH
`define MIC_PARAMS_SVH

// ----------------------------------------
// Widths
// ----------------------------------------
`define MIC_PC_W 12
`define MIC_ADDR_W 12
`define MIC_NSRC 8

// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define MIC_R_EDGE 0
`define MIC_R_CTL0 1
`define MIC_R_CTL1 2
`define MIC_R_SER 3
`define MIC_R_TM0 4
`define MIC_R_TM1 5
`define MIC_R_EELV 6
`define MIC_R_STAT 7

// ----------------------------------------
// Implemented bits per register
// ----------------------------------------
`define MIC_M_EDGE 8'h0f
`define MIC_M_CTL0 8'h5b
`define MIC_M_CTL1 8'h33
`define MIC_M_SER_FULL 8'hff
`define MIC_M_SER_SMALL 8'h77
`define MIC_M_TM0 8'h33
`define MIC_M_TM1_FULL 8'hff
`define MIC_M_TM1_SMALL 8'h33
`define MIC_M_EELV 8'h33
`define MIC_RESET_VAL 8'h00

// ----------------------------------------
// Flat bit positions: index * 8 + bit
// ----------------------------------------
`define MIC_GIE (`MIC_R_CTL0 * 8 + 0)
`define MIC_E_EXT0 (`MIC_R_CTL0 * 8 + 1)
`define MIC_E_MF0 (`MIC_R_CTL0 * 8 + 3)
`define MIC_F_EXT0 (`MIC_R_CTL0 * 8 + 4)
`define MIC_F_MF0 (`MIC_R_CTL0 * 8 + 6)
`define MIC_E_MF1 (`MIC_R_CTL1 * 8 + 0)
`define MIC_E_MF2 (`MIC_R_CTL1 * 8 + 1)
`define MIC_F_MF1 (`MIC_R_CTL1 * 8 + 4)
`define MIC_F_MF2 (`MIC_R_CTL1 * 8 + 5)
`define MIC_E_TB1 (`MIC_R_SER * 8 + 0)
`define MIC_E_EXT1 (`MIC_R_SER * 8 + 1)
`define MIC_E_SERIAL (`MIC_R_SER * 8 + 2)
`define MIC_E_UART (`MIC_R_SER * 8 + 3)
`define MIC_F_TB1 (`MIC_R_SER * 8 + 4)
`define MIC_F_EXT1 (`MIC_R_SER * 8 + 5)
`define MIC_F_SERIAL (`MIC_R_SER * 8 + 6)
`define MIC_F_UART (`MIC_R_SER * 8 + 7)
`define MIC_F_T0P (`MIC_R_TM0 * 8 + 4)
`define MIC_F_T0A (`MIC_R_TM0 * 8 + 5)
`define MIC_F_T1P (`MIC_R_TM1 * 8 + 4)
`define MIC_F_T1A (`MIC_R_TM1 * 8 + 5)
`define MIC_F_T2P (`MIC_R_TM1 * 8 + 6)
`define MIC_F_T2A (`MIC_R_TM1 * 8 + 7)
`define MIC_F_LV (`MIC_R_EELV * 8 + 4)
`define MIC_F_EE (`MIC_R_EELV * 8 + 5)

// ----------------------------------------
// Vector table
// ----------------------------------------
`define MIC_VEC_BASE 12'h004
`define MIC_VEC_STEP 12'h004

`endif

// >>> core/mic_pkg.sv
`include "mic_params.svh"

package mic_pkg;

    typedef struct packed {
        logic tb1;
        logic serial;
        logic uart;
        logic t0a;
        logic t0p;
        logic t1a;
        logic t1p;
        logic t2a;
        logic t2p;
        logic eeprom;
        logic lowvolt;
    } mic_evt_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [`MIC_ADDR_W-1:0] paddr;
        logic [31:0] pwdata;
    } mic_apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } mic_apb_rsp_t;

    typedef struct packed {
        logic boundary;
        logic stack_full;
        logic return_from_irq;
        logic [`MIC_PC_W-1:0] pc_next;
    } mic_cpu_in_t;

    typedef struct packed {
        logic take;
        logic push;
        logic pop;
        logic wake;
        logic [`MIC_PC_W-1:0] push_data;
        logic [`MIC_PC_W-1:0] vector;
    } mic_cpu_out_t;

    typedef struct packed {
        logic [7:0][7:0] img;
        logic [1:0] pin_prev;
        logic primed;
        logic [2:0] last_src;
        mic_apb_rsp_t apb;
        mic_cpu_out_t cpu;
    } mic_state_t;

endpackage

// >>> core/mic_irq_ctl.sv
// Functional notes
// - Source events set their flag whether or not the source is enabled.
// - Vector only when source enable and global_irq_enable are both 1.
// - On acceptance push next-instruction PC, then load vector address.
// - return_from_irq pops the saved PC from the stack.
// - Acceptance clears global_irq_enable automatically.
// - Requests while global enable is clear still set their flags.
// - No acknowledge while the stack is full.
// - Simultaneous enabled requests are taken in fixed priority order.
// - Any clear flag that a hardware event sets wakes the device from sleep or idle; software writes do not.
// - Timer, low-voltage and EEPROM sources share multi-function vectors.
// - Selected edge on ext_irq_pin0/1 sets ext0_flag or ext1_flag.
// - Servicing an external interrupt clears its flag and global enable.
// - Edge select offers rising, falling, both, or disabled.
// - Unimplemented register bits read as zero.
// - Serial/ext1/time-base register layout; small variant lacks UART bits.
// - Timer0 register: match-A/P flags at 5/4, enables at 1/0.
// - Timer1 register at 5/4 and 1/0; larger variant adds timer2 at 7:6/3:2.
// - EEPROM/low-voltage register layout, all bits reset to 0, read/write.
// - Edge field: 00 off, 01 rising, 10 falling, 11 both.
// - Multi-function flag set by any member; service leaves member flags.
//
// Design decisions made here: register access over APB and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "mic_params.svh"

module mic_irq_ctl #(
    parameter bit HAS_UART = 1'b1,
    parameter bit HAS_TIMER2 = 1'b1
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire mic_pkg::mic_apb_req_t apb_req,
    output var mic_pkg::mic_apb_rsp_t apb_rsp,
    input wire mic_pkg::mic_cpu_in_t cpu_in,
    output var mic_pkg::mic_cpu_out_t cpu_out,
    input wire mic_pkg::mic_evt_t evt,
    input wire logic ext_irq_pin0,
    input wire logic ext_irq_pin1
);
    import mic_pkg::*;

    // ----------------------------------------
    // Source tables, index 0 has top priority
    // ----------------------------------------
    localparam int FPOS [`MIC_NSRC] = '{
        `MIC_F_EXT0, `MIC_F_MF0, `MIC_F_MF1, `MIC_F_MF2,
        `MIC_F_TB1, `MIC_F_SERIAL, `MIC_F_EXT1, `MIC_F_UART
    };
    localparam int EPOS [`MIC_NSRC] = '{
        `MIC_E_EXT0, `MIC_E_MF0, `MIC_E_MF1, `MIC_E_MF2,
        `MIC_E_TB1, `MIC_E_SERIAL, `MIC_E_EXT1, `MIC_E_UART
    };

    localparam logic [7:0] M_SER = HAS_UART ?
        `MIC_M_SER_FULL : `MIC_M_SER_SMALL;
    localparam logic [7:0] M_TM1 = HAS_TIMER2 ?
        `MIC_M_TM1_FULL : `MIC_M_TM1_SMALL;
    // Status index carries no stored bits
    localparam logic [63:0] IMPL = {
        8'h00, `MIC_M_EELV, M_TM1, `MIC_M_TM0,
        M_SER, `MIC_M_CTL1, `MIC_M_CTL0, `MIC_M_EDGE
    };

    mic_state_t state_reg;
    mic_state_t state_next;

    // ----------------------------------------
    // Next-state logic
    // ----------------------------------------
    always_comb begin
        logic [63:0] flat;
        logic [63:0] set;
        logic [7:0] pend;
        logic [2:0] idx;
        logic found;
        logic [2:0] ridx;
        logic wr_done;
        logic rd_phase;
        logic mapped;
        logic rise0;
        logic fall0;
        logic rise1;
        logic fall1;
        logic [7:0] rbyte;

        state_next = state_reg;
        flat = state_reg.img;
        set = 64'h0;
        pend = 8'h00;
        idx = 3'h0;
        found = 1'b0;
        rbyte = 8'h00;
        ridx = apb_req.paddr[4:2];
        mapped = (apb_req.paddr[`MIC_ADDR_W-1:5] == '0) &&
                 (apb_req.paddr[1:0] == 2'b00);
        rd_phase = apb_req.psel && apb_req.penable &&
                   !state_reg.apb.pready;
        wr_done = apb_req.psel && apb_req.penable &&
                  state_reg.apb.pready && apb_req.pwrite && mapped;

        // ----------------------------------------
        // APB slave, one wait state
        // ----------------------------------------
        state_next.apb.pready = rd_phase;
        state_next.apb.pslverr = rd_phase && !mapped;
        state_next.apb.prdata = 32'h0;
        if (ridx == 3'(`MIC_R_STAT)) begin
            rbyte = {|pend, 4'h0, state_reg.last_src};
        end else begin
            rbyte = state_reg.img[ridx] & IMPL[ridx*8 +: 8];
        end
        if (rd_phase && mapped && !apb_req.pwrite) begin
            state_next.apb.prdata = {24'h0, rbyte};
        end

        // Software write takes effect at the completing edge only
        if (wr_done && ridx != 3'(`MIC_R_STAT)) begin
            flat[ridx*8 +: 8] = apb_req.pwdata[7:0];
        end

        // ----------------------------------------
        // External pin edges
        // ----------------------------------------
        // First cycle after reset only loads the history, so a pin
        // already high at release is not mistaken for an edge.
        state_next.pin_prev = {ext_irq_pin1, ext_irq_pin0};
        state_next.primed = 1'b1;
        rise0 = state_reg.primed && ext_irq_pin0 &&
                !state_reg.pin_prev[0];
        fall0 = state_reg.primed && !ext_irq_pin0 &&
                state_reg.pin_prev[0];
        rise1 = state_reg.primed && ext_irq_pin1 &&
                !state_reg.pin_prev[1];
        fall1 = state_reg.primed && !ext_irq_pin1 &&
                state_reg.pin_prev[1];
        // Field bit 0 picks rising, bit 1 falling, 00 turns it off
        set[`MIC_F_EXT0] = (state_reg.img[`MIC_R_EDGE][0] && rise0) ||
                           (state_reg.img[`MIC_R_EDGE][1] && fall0);
        set[`MIC_F_EXT1] = (state_reg.img[`MIC_R_EDGE][2] && rise1) ||
                           (state_reg.img[`MIC_R_EDGE][3] && fall1);

        // ----------------------------------------
        // Peripheral events, set regardless of enables
        // ----------------------------------------
        set[`MIC_F_TB1] = evt.tb1;
        set[`MIC_F_SERIAL] = evt.serial;
        set[`MIC_F_UART] = evt.uart;
        set[`MIC_F_T0A] = evt.t0a;
        set[`MIC_F_T0P] = evt.t0p;
        set[`MIC_F_T1A] = evt.t1a;
        set[`MIC_F_T1P] = evt.t1p;
        set[`MIC_F_T2A] = evt.t2a;
        set[`MIC_F_T2P] = evt.t2p;
        set[`MIC_F_EE] = evt.eeprom;
        set[`MIC_F_LV] = evt.lowvolt;
        // Absent variant bits never set
        set = set & IMPL;
        // Member sources feed the shared vectors
        set[`MIC_F_MF0] = set[`MIC_F_T0A] | set[`MIC_F_T0P];
        set[`MIC_F_MF1] = set[`MIC_F_T1A] | set[`MIC_F_T1P] |
                          set[`MIC_F_T2A] | set[`MIC_F_T2P];
        set[`MIC_F_MF2] = set[`MIC_F_EE] | set[`MIC_F_LV];

        // ----------------------------------------
        // Priority and acceptance
        // ----------------------------------------
        for (int i = 0; i < `MIC_NSRC; i++) begin
            pend[i] = state_reg.img[FPOS[i] / 8][FPOS[i] % 8] &&
                      state_reg.img[EPOS[i] / 8][EPOS[i] % 8];
        end
        for (int i = `MIC_NSRC - 1; i >= 0; i--) begin
            if (pend[i]) begin
                idx = 3'(i);
                found = 1'b1;
            end
        end

        state_next.cpu.take = 1'b0;
        state_next.cpu.push = 1'b0;
        state_next.cpu.pop = cpu_in.return_from_irq;
        if (cpu_in.boundary && found && !cpu_in.stack_full &&
            state_reg.img[`MIC_R_CTL0][0]) begin
            state_next.cpu.take = 1'b1;
            state_next.cpu.push = 1'b1;
            state_next.cpu.push_data = cpu_in.pc_next;
            state_next.cpu.vector = `MIC_VEC_BASE +
                `MIC_PC_W'(idx) * `MIC_VEC_STEP;
            state_next.last_src = idx;
            flat[`MIC_GIE] = 1'b0;
            // Only the serviced flag; member flags stay for software
            flat[FPOS[idx]] = 1'b0;
        end

        // Hardware set wins over any clear in the same cycle
        flat = (flat | set) & IMPL;
        state_next.img = flat;

        // Waking only on flags that were clear, so pre-set ones stay quiet
        state_next.cpu.wake = |(set & ~state_reg.img);
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign apb_rsp = state_reg.apb;
    assign cpu_out = state_reg.cpu;

endmodule

`default_nettype wire

// >>> sim/mic_irq_ctl_properties.sv
`timescale 1ns/1ns
`default_nettype none
`include "mic_params.svh"
module mic_irq_ctl_properties #(
    parameter bit HAS_UART = 1'b1,
    parameter bit HAS_TIMER2 = 1'b1
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire mic_pkg::mic_apb_req_t apb_req,
    input wire mic_pkg::mic_apb_rsp_t apb_rsp,
    input wire mic_pkg::mic_cpu_in_t cpu_in,
    input wire mic_pkg::mic_cpu_out_t cpu_out,
    input wire mic_pkg::mic_evt_t evt,
    input wire logic ext_irq_pin0,
    input wire logic ext_irq_pin1
);
    import mic_pkg::*;
    // ----------------------------------------
    // Acceptance, return and register answers
    // ----------------------------------------
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    chk_take_push: assert property (cpu_out.take |-> cpu_out.push)
        else $error("take without push");
    chk_push_pc: assert property (
        cpu_out.take |-> cpu_out.push_data == $past(cpu_in.pc_next))
        else $error("pushed address is not the next instruction");
    chk_take_gate: assert property (
        cpu_out.take |-> $past(cpu_in.boundary && !cpu_in.stack_full))
        else $error("take off boundary or with full stack");
    chk_take_once: assert property (cpu_out.take |=> !cpu_out.take)
        else $error("second take without global enable");
    chk_vec_table: assert property (cpu_out.take |->
        cpu_out.vector[1:0] == 2'h0 && cpu_out.vector inside {[12'h004:12'h020]})
        else $error("vector outside table");
    chk_pop_follows: assert property (
        cpu_out.pop == $past(cpu_in.return_from_irq))
        else $error("pop not tied to return");
    chk_upper_zero: assert property (
        apb_rsp.pready |-> apb_rsp.prdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    chk_err_map: assert property (apb_rsp.pready |->
        apb_rsp.pslverr == (apb_req.paddr >= 12'h020 || apb_req.paddr[1:0] != 0))
        else $error("slave error does not match address");
    chk_wake_cause: assert property (cpu_out.wake |-> $past(|evt) ||
        $past(ext_irq_pin0, 1) != $past(ext_irq_pin0, 2) ||
        $past(ext_irq_pin1, 1) != $past(ext_irq_pin1, 2))
        else $error("wake without a hardware event");
    cover property (cpu_out.take);
    cover property (cpu_out.pop);
    cover property (cpu_out.wake);
    cover property (apb_rsp.pready && apb_rsp.pslverr);
endmodule
bind mic_irq_ctl mic_irq_ctl_properties #(
    .HAS_UART(HAS_UART),
    .HAS_TIMER2(HAS_TIMER2)
) i_props (.sys_clk(sys_clk), .sys_rst(sys_rst), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .cpu_in(cpu_in), .cpu_out(cpu_out), .evt(evt),
    .ext_irq_pin0(ext_irq_pin0), .ext_irq_pin1(ext_irq_pin1));
`default_nettype wire

// >>> sim/mic_cpu_model.sv
`timescale 1ns/1ns
`default_nettype none
module mic_cpu_model #(
    parameter int DEPTH = 2
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic slow,
    input wire logic ret_req,
    input wire mic_pkg::mic_cpu_out_t cpu_out,
    output var mic_pkg::mic_cpu_in_t cpu_in
);
    import mic_pkg::*;
    logic [11:0] stk [DEPTH];
    int depth;
    logic [1:0] cnt;
    // ----------------------------------------
    // Core and stack
    // ----------------------------------------
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cpu_in <= '0;
            depth <= 0;
            cnt <= 2'h0;
        end else begin
            cnt <= cnt + 2'h1;
            // Slow mode: boundary only every fourth cycle
            cpu_in.boundary <= !slow || cnt == 2'h0;
            cpu_in.pc_next <= cpu_in.pc_next + 12'h1;
            cpu_in.return_from_irq <= 1'b0;
            cpu_in.stack_full <= depth >= DEPTH;
            if (cpu_out.push) begin
                stk[depth] <= cpu_out.push_data;
                depth <= depth + 1;
                cpu_in.stack_full <= depth + 1 >= DEPTH;
                cpu_in.pc_next <= cpu_out.vector;
            end else if (ret_req && depth > 0) begin
                cpu_in.return_from_irq <= 1'b1;
                depth <= depth - 1;
                cpu_in.stack_full <= 1'b0;
                cpu_in.pc_next <= stk[depth - 1];
            end
        end
    end
endmodule
`default_nettype wire

// >>> sim/mic_irq_ctl_bench.sv
`timescale 1ns/1ns
`default_nettype none
`include "mic_params.svh"
module mic_irq_ctl_bench;
    import mic_pkg::*;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic p0 = 1'b0;
    logic p1 = 1'b0;
    logic slow = 1'b0;
    logic ret_req = 1'b0;
    mic_apb_req_t req = '0;
    mic_evt_t evt = '0;
    mic_apb_rsp_t rsp;
    mic_cpu_in_t cin;
    mic_cpu_out_t cout;
    logic [31:0] rdata;
    logic err;
    int num_errors = 0;
    int num_checks = 0;
    int takes = 0;
    int wakes = 0;
    int pops = 0;
    always #5 sys_clk = ~sys_clk;
    mic_irq_ctl i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .apb_req(req),
        .apb_rsp(rsp), .cpu_in(cin), .cpu_out(cout), .evt(evt),
        .ext_irq_pin0(p0), .ext_irq_pin1(p1));
    mic_cpu_model i_cpu (.sys_clk(sys_clk), .sys_rst(sys_rst), .slow(slow),
        .ret_req(ret_req), .cpu_out(cout), .cpu_in(cin));
    always @(posedge sys_clk) begin
        takes += int'(cout.take === 1'b1);
        wakes += int'(cout.wake === 1'b1);
        pops += int'(cout.pop === 1'b1);
    end
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic wr, input int idx, input logic [7:0] d);
        req <= '{1'b1, 1'b0, wr, 12'(4 * idx), {24'h0, d}};
        @(posedge sys_clk);
        req.penable <= 1'b1;
        // Only the watchdog ends a wait that never sees pready
        do begin
            @(posedge sys_clk);
        end while (rsp.pready !== 1'b1);
        rdata = rsp.prdata;
        err = rsp.pslverr;
        req <= '0;
        // Idle edge so the next call never re-drives req in this step
        @(posedge sys_clk);
    endtask
    task automatic wr(input int idx, input logic [7:0] d);
        apb(1'b1, idx, d);
    endtask
    task automatic rc(input int idx, input logic [7:0] exp);
        apb(1'b0, idx, 8'h00);
        check(rdata, {24'h0, exp});
    endtask
    task automatic settle;
        repeat (8) @(posedge sys_clk);
    endtask
    task automatic ret;
        ret_req <= 1'b1;
        @(posedge sys_clk);
        ret_req <= 1'b0;
        settle;
    endtask
    task automatic give_verdict;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs;
        for (int i = 0; i < 8; i++) rc(i, 8'h00);
        apb(1'b0, 8, 8'h00);
        check({31'h0, err}, 32'h1);
        wr(`MIC_R_EDGE, 8'hff);
        rc(`MIC_R_EDGE, 8'h0f);
        wr(`MIC_R_SER, 8'hff);
        rc(`MIC_R_SER, 8'hff);
        wr(`MIC_R_TM0, 8'hff);
        rc(`MIC_R_TM0, 8'h33);
        wr(`MIC_R_TM1, 8'hff);
        rc(`MIC_R_TM1, 8'hff);
        wr(`MIC_R_EELV, 8'hff);
        rc(`MIC_R_EELV, 8'h33);
        for (int i = 0; i < 7; i++) wr(i, 8'h00);
        $display("register test done");
    endtask
    task automatic t_evt;
        evt.t0a <= 1'b1;
        @(posedge sys_clk);
        evt <= '0;
        settle;
        check(wakes, 1);
        rc(`MIC_R_TM0, 8'h20);
        rc(`MIC_R_CTL0, 8'h40);
        wr(`MIC_R_CTL0, 8'h41);
        settle;
        check(takes, 0);
        wr(`MIC_R_CTL0, 8'h49);
        settle;
        check(cout.vector, 12'h008);
        rc(`MIC_R_CTL0, 8'h08);
        rc(`MIC_R_TM0, 8'h20);
        ret;
        wr(`MIC_R_TM0, 8'h20);
        wr(`MIC_R_CTL0, 8'h40);
        evt.t0a <= 1'b1;
        @(posedge sys_clk);
        evt <= '0;
        settle;
        check(wakes, 1);
        wr(`MIC_R_TM0, 8'h00);
        $display("event test done");
    endtask
    task automatic t_prio;
        wr(`MIC_R_EDGE, 8'h01);
        wr(`MIC_R_SER, 8'h01);
        wr(`MIC_R_CTL0, 8'h02);
        p0 <= 1'b1;
        evt.tb1 <= 1'b1;
        @(posedge sys_clk);
        evt <= '0;
        wr(`MIC_R_CTL0, 8'h13);
        settle;
        check(cout.vector, 12'h004);
        rc(`MIC_R_CTL0, 8'h02);
        rc(`MIC_R_SER, 8'h11);
        ret;
        wr(`MIC_R_CTL0, 8'h03);
        settle;
        check(cout.vector, 12'h014);
        rc(`MIC_R_SER, 8'h01);
        check(takes, 3);
        ret;
        $display("priority test done");
    endtask
    task automatic t_edges;
        for (int c = 0; c < 4; c++) begin
            wr(`MIC_R_EDGE, 8'(c << 2));
            wr(`MIC_R_SER, 8'h00);
            p1 <= 1'b1;
            settle;
            rc(`MIC_R_SER, c[0] ? 8'h20 : 8'h00);
            wr(`MIC_R_SER, 8'h00);
            p1 <= 1'b0;
            settle;
            rc(`MIC_R_SER, c[1] ? 8'h20 : 8'h00);
        end
        $display("edge test done");
    endtask
    task automatic t_stack;
        slow <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            wr(`MIC_R_SER, 8'h11);
            wr(`MIC_R_CTL0, 8'h01);
            settle;
            check(takes, 4 + (i < 2 ? i : 1));
        end
        ret;
        settle;
        check(takes, 6);
        ret;
        ret;
        check(pops, 6);
        slow <= 1'b0;
        $display("stack test done");
    endtask
    initial begin
        repeat (4) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        t_regs;
        t_evt;
        t_prio;
        t_edges;
        t_stack;
        give_verdict;
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        num_errors++;
        give_verdict;
    end
endmodule
`default_nettype wire
